// ### verilog/synth_function_latch_control.v
// Purpose: Function latch control of an RF frequency synthesizer
// Assumes: Divider outputs and serial pins are asynchronous to i_clock
// Notes:   Divider counters and analog pump live outside this block
//
// How it works
// - Host shifts 21-bit words MSB first; last two bits pick target latch.
// - Initialization words update the same latch as function latch words.
// - Counter reset bit holds both divider counters in reset until cleared.
// - Polarity bit one means positive VCO slope, zero negative.
// - Pump float bit puts charge pump output in high impedance.
// - Fast settle enable selects one of four modes via control, timeout, go.
// - With fast settle disabled, fast settle pin follows the control bit.
// - Timeout enable bit arms the timeout counter loaded from the 4-bit field.
// - Timeout counts comparison cycles; field k gives 4k+3 cycles.
// - Chip enable low powers the device down at once.
// - Powerdown bit with mode bit picks normal, synchronous or async power down.
// - Synchronous power down waits for the next charge pump event.
// - Asynchronous power down happens as the load latches the bit.
// - Loading zero into the powerdown bit powers up at once.
// - Power down resets counters, floats the pump and resets lock detect.
// - Serial interface keeps loading words during power down.
// - Output select field picks the multiplexed output pin source.
// - Lock asserts after 3 or 5 comparisons with error under 15 ns.
// - Lock stays until one comparison shows error above 30 ns.
// - Pump float or programmed power down forces the detector unlocked.
// - Open-drain lock output is high with narrow low pulses when locked.
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defs.vh"

module synth_function_latch_control #(
	parameter EW = 6
) (
	input  wire i_clock,
	input  wire i_reset_n,
	input  wire i_serial_data,
	input  wire i_serial_clock,
	input  wire i_load_pulse,
	input  wire i_chip_enable_pin,
	input  wire i_ref_div_out,
	input  wire i_main_div_out,
	output reg  o_counter_reset,
	output reg  o_pd_polarity,
	output reg  o_pump_float,
	output reg  o_pump_high_gain,
	output reg  o_fast_settle_active,
	output reg  o_quarter_divide,
	output reg  o_fast_settle_out,
	output reg  o_fast_settle_oe,
	output reg  o_mux_out_pin,
	output reg  o_mux_out_oe,
	output reg  o_powered_down,
	output reg  o_lock_detect
);

	// ----------------------------------------
	// Derived timing
	// ----------------------------------------
	localparam LO_RAW = (`LOCK_LO_NS * `CLOCK_MHZ) / 1000;
	localparam HI_RAW = (`LOCK_HI_NS * `CLOCK_MHZ) / 1000;
	localparam LO_CYC = (LO_RAW < 1) ? 1 : LO_RAW;
	localparam HI_CYC = (HI_RAW < 1) ? 1 : HI_RAW;
	localparam NSYNC  = 6;
	// Chip enable syncs reset to its idle high level: no false power down
	localparam [NSYNC-1:0] SYNC_INIT = `PIN_SYNC_RESET;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [NSYNC-1:0] raw_pins;
	reg  [NSYNC-1:0] sync1_q;
	reg  [NSYNC-1:0] sync2_q;

	assign raw_pins = {i_main_div_out, i_ref_div_out, i_chip_enable_pin,
		i_load_pulse, i_serial_clock, i_serial_data};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge i_clock) begin
				if (!i_reset_n) begin
					sync1_q[gi] <= SYNC_INIT[gi];
					sync2_q[gi] <= SYNC_INIT[gi];
				end else begin
					sync1_q[gi] <= raw_pins[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	wire s_data  = sync2_q[0];
	wire s_sclk  = sync2_q[1];
	wire s_load  = sync2_q[2];
	wire s_ce    = sync2_q[3];
	wire s_ref   = sync2_q[4];
	wire s_main  = sync2_q[5];

	// ----------------------------------------
	// Serial receiver
	// ----------------------------------------
	wire [`WORD_BITS-1:0] shift_reg;
	wire [`WORD_BITS-1:0] word;
	wire                  word_strobe;

	serial_word_shifter #(
		.WIDTH (`WORD_BITS)
	) u_shifter (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_sclk    (s_sclk),
		.i_data    (s_data),
		.i_load    (s_load),
		.o_shift   (shift_reg),
		.o_word    (word),
		.o_strobe  (word_strobe)
	);

	function is_func_target;
		input [1:0] tgt;
		begin
			is_func_target = (tgt == `TGT_FUNC) || (tgt == `TGT_INIT);
		end
	endfunction

	wire [1:0] tgt      = word[`TGT_LSB+1:`TGT_LSB];
	wire       func_ld  = word_strobe && is_func_target(tgt);
	wire       main_ld  = word_strobe && (tgt == `TGT_MAIN);
	wire       ref_ld   = word_strobe && (tgt == `TGT_REF);

	// ----------------------------------------
	// Function latch and side bits
	// ----------------------------------------
	reg  [`WORD_BITS-1:0] latch_q;
	reg                   precision_q;
	reg                   go_q;
	wire                  go_expire;

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			latch_q     <= {`LATCH_RESET, 2'b00};
			precision_q <= 1'b0;
		end else begin
			if (func_ld) begin
				latch_q <= word;
			end
			if (ref_ld) begin
				precision_q <= word[`TOP_BIT];
			end
		end
	end

	wire       f_cnt_reset = latch_q[`FB_CNT_RESET];
	wire       f_pwrdn     = latch_q[`FB_PWRDN];
	wire [2:0] f_osel      = {latch_q[`FB_OSEL_HI], latch_q[`FB_OSEL_MID],
		latch_q[`FB_OSEL_LO]};
	wire       f_pd_pol    = latch_q[`FB_PD_POL];
	wire       f_float     = latch_q[`FB_PUMP_FLOAT];
	wire       f_fs_en     = latch_q[`FB_FS_EN];
	wire       f_fs_ctrl   = latch_q[`FB_FS_CTRL];
	wire       f_tmo_en    = latch_q[`FB_TMO_EN];
	wire [3:0] f_tmo_k     = latch_q[`FB_TMO_MSB:`FB_TMO_LSB];

	// ----------------------------------------
	// Divider edges
	// ----------------------------------------
	reg  ref_q;
	reg  main_q;
	wire ref_edge  = s_ref && !ref_q;
	wire main_edge = s_main && !main_q;
	wire pump_event = ref_edge || main_edge;

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			ref_q  <= 1'b0;
			main_q <= 1'b0;
		end else begin
			ref_q  <= s_ref;
			main_q <= s_main;
		end
	end

	// ----------------------------------------
	// Power down sequencing
	// ----------------------------------------
	reg  pd_prog_q;
	reg  pd_pend_q;
	wire new_pwrdn = word[`FB_PWRDN];
	wire new_mode  = word[`FB_PWRDN_MODE];

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			pd_prog_q <= 1'b0;
			pd_pend_q <= 1'b0;
		end else if (func_ld) begin
			if (!new_pwrdn) begin
				pd_prog_q <= 1'b0;
				pd_pend_q <= 1'b0;
			end else if (!new_mode) begin
				pd_prog_q <= 1'b1;
				pd_pend_q <= 1'b0;
			end else if (!pd_prog_q) begin
				pd_pend_q <= 1'b1;
			end
		end else if (pd_pend_q && pump_event) begin
			pd_prog_q <= 1'b1;
			pd_pend_q <= 1'b0;
		end
	end

	wire pd_all = !s_ce || pd_prog_q;

	// ----------------------------------------
	// Go bit and timeout counter
	// ----------------------------------------
	wire       tmo_mode  = f_fs_en && f_tmo_en;
	wire [5:0] tmo_load  = {f_tmo_k, `TMO_LOW_BITS};
	reg  [5:0] tmo_q;

	assign go_expire = tmo_mode && go_q && ref_edge && (tmo_q <= 6'h01);

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			go_q <= 1'b0;
		end else if (main_ld) begin
			go_q <= word[`TOP_BIT];
		end else if (go_expire) begin
			go_q <= 1'b0;
		end
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			tmo_q <= 6'h00;
		end else if (pd_all || !tmo_mode || !go_q) begin
			tmo_q <= tmo_load;
		end else if (ref_edge && tmo_q != 6'h00) begin
			tmo_q <= tmo_q - 6'h01;
		end
	end

	// ----------------------------------------
	// Lock detector
	// ----------------------------------------
	wire lock_clear = f_float || pd_all;
	wire locked;
	wire err_window;
	wire compare;

	phase_lock_detector #(
		.EW     (EW),
		.LO_CYC (LO_CYC),
		.HI_CYC (HI_CYC)
	) u_lock (
		.i_clock     (i_clock),
		.i_reset_n   (i_reset_n),
		.i_clear     (lock_clear),
		.i_ref_edge  (ref_edge),
		.i_main_edge (main_edge),
		.i_precision (precision_q),
		.o_locked    (locked),
		.o_window    (err_window),
		.o_compare   (compare)
	);

	// ----------------------------------------
	// Fast settle decode
	// ----------------------------------------
	wire fs_active = f_fs_en && go_q && !pd_all;

	// ----------------------------------------
	// Output pin multiplexer
	// ----------------------------------------
	reg mux_d;
	reg mux_oe_d;

	always @* begin
		mux_d    = 1'b0;
		mux_oe_d = 1'b1;
		case (f_osel)
			`OSEL_HIZ: begin
				mux_oe_d = 1'b0;
			end
			`OSEL_REF: begin
				mux_d = s_ref;
			end
			`OSEL_MAIN: begin
				mux_d = s_main;
			end
			`OSEL_SDO: begin
				mux_d = shift_reg[`TOP_BIT];
			end
			`OSEL_DLD: begin
				mux_d = locked;
			end
			`OSEL_ODLD: begin
				mux_oe_d = !locked || err_window || compare;
			end
			`OSEL_HIGH: begin
				mux_d = 1'b1;
			end
			default: begin
				mux_d = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_counter_reset      <= 1'b0;
			o_pd_polarity        <= 1'b0;
			o_pump_float         <= 1'b0;
			o_pump_high_gain     <= 1'b0;
			o_fast_settle_active <= 1'b0;
			o_quarter_divide     <= 1'b0;
			o_fast_settle_out    <= 1'b0;
			o_fast_settle_oe     <= 1'b0;
			o_mux_out_pin        <= 1'b0;
			o_mux_out_oe         <= 1'b0;
			o_powered_down       <= 1'b0;
			o_lock_detect        <= 1'b0;
		end else begin
			o_counter_reset      <= f_cnt_reset || pd_all;
			o_pd_polarity        <= f_pd_pol;
			o_pump_float         <= f_float || pd_all;
			o_pump_high_gain     <= f_fs_en ? fs_active : go_q;
			o_fast_settle_active <= fs_active;
			o_quarter_divide     <= fs_active && f_fs_ctrl;
			o_powered_down       <= pd_all;
			o_lock_detect        <= locked;
			o_mux_out_pin        <= mux_d;
			o_mux_out_oe         <= mux_oe_d;
			if (!f_fs_en) begin
				o_fast_settle_out <= f_fs_ctrl;
				o_fast_settle_oe  <= 1'b1;
			end else begin
				o_fast_settle_out <= 1'b0;
				o_fast_settle_oe  <= fs_active;
			end
		end
	end

endmodule
`default_nettype wire

// ### verilog/synth_ctrl_defs.vh
// Purpose: Constants for the synthesizer function latch control block
// Assumes: 21-bit serial word, control bits in the two last-shifted bits
// Notes:   Word bit n+1 carries function bit n
`ifndef SYNTH_CTRL_DEFS_VH
`define SYNTH_CTRL_DEFS_VH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define WORD_BITS          21
`define LATCH_BITS         19
`define TGT_LSB            0
`define TGT_REF            2'h0
`define TGT_MAIN           2'h2
`define TGT_FUNC           2'h1
`define TGT_INIT           2'h3
`define TOP_BIT            20

// ----------------------------------------
// Function latch fields (word bit positions)
// ----------------------------------------
`define FB_CNT_RESET       2
`define FB_PWRDN           3
`define FB_OSEL_HI         4
`define FB_OSEL_MID        5
`define FB_OSEL_LO         6
`define FB_PD_POL          7
`define FB_PUMP_FLOAT      8
`define FB_FS_EN           9
`define FB_FS_CTRL         10
`define FB_TMO_EN          11
`define FB_TMO_LSB         12
`define FB_TMO_MSB         15
`define FB_PWRDN_MODE      19
`define LATCH_RESET        19'h0_0000
`define PIN_SYNC_RESET     6'h08

// ----------------------------------------
// Output select codes
// ----------------------------------------
`define OSEL_HIZ           3'h0
`define OSEL_REF           3'h1
`define OSEL_MAIN          3'h2
`define OSEL_SDO           3'h3
`define OSEL_DLD           3'h4
`define OSEL_ODLD          3'h5
`define OSEL_HIGH          3'h6
`define OSEL_LOW           3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_MHZ          100
`define LOCK_LO_NS         15
`define LOCK_HI_NS         30
`define LOCK_CNT_NORMAL    3
`define LOCK_CNT_PRECISE   5
`define TMO_LOW_BITS       2'h3

`endif

// ### verilog/serial_word_shifter.v
// Purpose: Three-wire serial word receiver
// Assumes: Inputs already synchronised to i_clock
// Notes:   Shifts on serial clock rise, transfers on load rise
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defs.vh"

module serial_word_shifter #(
	parameter WIDTH = `WORD_BITS
) (
	input  wire             i_clock,
	input  wire             i_reset_n,
	input  wire             i_sclk,
	input  wire             i_data,
	input  wire             i_load,
	output reg  [WIDTH-1:0] o_shift,
	output reg  [WIDTH-1:0] o_word,
	output reg              o_strobe
);

	reg sclk_q;
	reg load_q;

	// ----------------------------------------
	// Shift and transfer
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			sclk_q   <= 1'b0;
			load_q   <= 1'b0;
			o_shift  <= {WIDTH{1'b0}};
			o_word   <= {WIDTH{1'b0}};
			o_strobe <= 1'b0;
		end else begin
			sclk_q   <= i_sclk;
			load_q   <= i_load;
			o_strobe <= 1'b0;
			if (i_sclk && !sclk_q) begin
				o_shift <= {o_shift[WIDTH-2:0], i_data};
			end
			if (i_load && !load_q) begin
				o_word   <= o_shift;
				o_strobe <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ### verilog/phase_lock_detector.v
// Purpose: Digital lock detector on divided reference and VCO edges
// Assumes: Edge inputs are one-cycle pulses on i_clock
// Notes:   Error measured in whole clock cycles
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defs.vh"

module phase_lock_detector #(
	parameter       EW     = 6,
	parameter       LO_CYC = 1,
	parameter       HI_CYC = 3
) (
	input  wire i_clock,
	input  wire i_reset_n,
	input  wire i_clear,
	input  wire i_ref_edge,
	input  wire i_main_edge,
	input  wire i_precision,
	output reg  o_locked,
	output reg  o_window,
	output reg  o_compare
);

	reg  [EW-1:0] err_q;
	reg  [2:0]    good_q;
	wire          any_edge = i_ref_edge | i_main_edge;
	wire          done     = o_window ? any_edge : (i_ref_edge & i_main_edge);
	wire [EW-1:0] err_now  = o_window ? err_q : {EW{1'b0}};
	wire [2:0]    need     = i_precision ? 3'd`LOCK_CNT_PRECISE : 3'd`LOCK_CNT_NORMAL;
	wire [2:0]    good_inc = good_q + 3'd1;

	// ----------------------------------------
	// Error window and lock state
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (!i_reset_n || i_clear) begin
			err_q     <= {EW{1'b0}};
			good_q    <= 3'd0;
			o_locked  <= 1'b0;
			o_window  <= 1'b0;
			o_compare <= 1'b0;
		end else begin
			o_compare <= done;
			if (done) begin
				o_window <= 1'b0;
				err_q    <= {EW{1'b0}};
			end else if (any_edge) begin
				o_window <= 1'b1;
				err_q    <= {{(EW-1){1'b0}}, 1'b1};
			end else if (o_window && err_q != {EW{1'b1}}) begin
				err_q <= err_q + {{(EW-1){1'b0}}, 1'b1};
			end
			if (done) begin
				if (err_now <= LO_CYC[EW-1:0]) begin
					if (good_q < need) begin
						good_q <= good_inc;
					end
					if (good_inc >= need) begin
						o_locked <= 1'b1;
					end
				end else begin
					good_q <= 3'd0;
				end
				if (err_now > HI_CYC[EW-1:0]) begin
					o_locked <= 1'b0;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ### sim/synth_ctrl_props.sv
// Purpose: Port assertions for the function latch control block
// Assumes: Lags as given in the hand-over timing
// Notes:   Bound to the design top
`timescale 1ns/10ps
`default_nettype none
module synth_ctrl_props (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_chip_enable_pin,
	input wire o_pump_float,
	input wire o_counter_reset,
	input wire o_pump_high_gain,
	input wire o_fast_settle_active,
	input wire o_quarter_divide,
	input wire o_fast_settle_out,
	input wire o_fast_settle_oe,
	input wire o_powered_down,
	input wire o_lock_detect
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	ce_power_down_a: assert property (!i_chip_enable_pin [*6] |-> o_powered_down)
		else $error("chip enable low without power down");
	pd_effects_a: assert property (o_powered_down [*2] |-> o_pump_float && o_counter_reset)
		else $error("power down without pump float or counter reset");
	pd_unlock_a: assert property (o_powered_down [*3] |-> !o_lock_detect)
		else $error("lock held in power down");
	float_unlock_a: assert property (o_pump_float [*3] |-> !o_lock_detect)
		else $error("lock held with pump floating");
	lock_rise_a: assert property ($rose(o_lock_detect) |-> !$past(o_pump_float))
		else $error("lock rose with pump floating");
	settle_pin_a: assert property (o_fast_settle_active |-> o_fast_settle_oe && !o_fast_settle_out)
		else $error("fast settle pin not driven low");
	quarter_mode_a: assert property (o_quarter_divide |-> o_fast_settle_active)
		else $error("quarter divide outside fast settle");
	high_gain_a: assert property (o_fast_settle_active |-> o_pump_high_gain)
		else $error("fast settle without high gain");
endmodule
bind synth_function_latch_control synth_ctrl_props u_synth_ctrl_props (
	.i_clock, .i_reset_n, .i_chip_enable_pin, .o_pump_float, .o_counter_reset,
	.o_pump_high_gain, .o_fast_settle_active, .o_quarter_divide, .o_fast_settle_out,
	.o_fast_settle_oe, .o_powered_down, .o_lock_detect);
`default_nettype wire

// ### sim/serial_host_model.sv
// Purpose: Host side of the three-wire serial link
// Assumes: Calls start on a falling clock edge
// Notes:   Serial clock stands low between words
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
	output logic o_data,
	output logic o_sclk,
	output logic o_load
);
	initial begin
		o_data = 1'b0;
		o_sclk = 1'b0;
		o_load = 1'b0;
	end
	task automatic send_word(input logic [20:0] w);
		for (int i = 20; i >= 0; i--) begin
			o_data = w[i];
			#40 o_sclk = 1'b1;
			#80 o_sclk = 1'b0;
			#40;
		end
		#80 o_load = 1'b1;
		#80 o_load = 1'b0;
		o_data = ~o_data;
	endtask
endmodule
`default_nettype wire

// ### sim/synth_function_latch_control_tb_top.sv
// Purpose: Self-checking bench of the function latch control block
// Assumes: Words sent through the host model
// Notes:   Divider edges made by the bench
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defs.vh"
module synth_function_latch_control_tb_top;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic        ref_div = 1'b0;
	logic        main_div = 1'b0;
	wire         sdata, sclk, load;
	wire         c_rst, pol, flt, hg, fsa, qd, fso, fsoe, mux, muxoe, pd, lock;
	int          mismatches = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [20:0] w;
	always #5 clock = ~clock;
	serial_host_model u_serial_host_model (.o_data(sdata), .o_sclk(sclk), .o_load(load));
	synth_function_latch_control u_synth_function_latch_control (
		.i_clock(clock), .i_reset_n(reset_n), .i_serial_data(sdata),
		.i_serial_clock(sclk), .i_load_pulse(load), .i_chip_enable_pin(ce),
		.i_ref_div_out(ref_div), .i_main_div_out(main_div), .o_counter_reset(c_rst),
		.o_pd_polarity(pol), .o_pump_float(flt), .o_pump_high_gain(hg),
		.o_fast_settle_active(fsa), .o_quarter_divide(qd), .o_fast_settle_out(fso),
		.o_fast_settle_oe(fsoe), .o_mux_out_pin(mux), .o_mux_out_oe(muxoe),
		.o_powered_down(pd), .o_lock_detect(lock));
	task automatic check(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [1:0] tgt, input logic [20:0] f);
		u_serial_host_model.send_word({f[20:2], tgt});
		repeat (10) @(negedge clock);
	endtask
	task automatic comp(input int skew);
		ref_div = 1'b1;
		repeat (skew) @(negedge clock);
		main_div = 1'b1;
		repeat (8) @(negedge clock);
		ref_div = 1'b0;
		main_div = 1'b0;
		repeat (8) @(negedge clock);
	endtask
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (8) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		w = 21'h0;
		w[`FB_PD_POL] = 1'b1;
		w[`FB_FS_CTRL] = 1'b1;
		w[`FB_CNT_RESET] = 1'b1;
		w[`FB_PUMP_FLOAT] = 1'b1;
		put(`TGT_INIT, w);
		check(pol, 1'b1);
		check(c_rst, 1'b1);
		check(flt, 1'b1);
		check(fso && fsoe, 1'b1);
		put(`TGT_FUNC, 21'h0);
		check(pol | c_rst | flt | fso, 1'b0);
		check(fsoe, 1'b1);
		// Every output select code
		for (int c = 0; c < 8; c++) begin
			w = 21'h0;
			w[`FB_OSEL_LO:`FB_OSEL_HI] = {c[0], c[1], c[2]};
			ref_div = c[0];
			put(`TGT_FUNC, w);
			check(muxoe, c != 0);
			if (c != 0)
				check(mux, c == 1 || c == 6);
		end
		ref_div = 1'b0;
		w = 21'h0;
		w[`FB_OSEL_HI] = 1'b1;
		put(`TGT_FUNC, w);
		repeat (2) comp(0);
		check(lock, 1'b0);
		comp(0);
		check(mux, 1'b1);
		comp(1);
		comp(3);
		check(lock, 1'b1);
		comp(4);
		check(lock, 1'b0);
		put(`TGT_REF, 21'h10_0000);
		repeat (4) comp(0);
		check(lock, 1'b0);
		comp(0);
		check(lock, 1'b1);
		w[`FB_OSEL_LO] = 1'b1;
		put(`TGT_FUNC, w);
		check(mux | muxoe, 1'b0);
		// One comparison while locked: one narrow low pulse
		ref_div = 1'b1;
		main_div = 1'b1;
		repeat (4) @(negedge clock);
		check(muxoe, 1'b1);
		repeat (4) @(negedge clock);
		check(muxoe, 1'b0);
		ref_div = 1'b0;
		main_div = 1'b0;
		repeat (8) @(negedge clock);
		check(lock, 1'b1);
		w[`FB_PUMP_FLOAT] = 1'b1;
		put(`TGT_FUNC, w);
		check(lock, 1'b0);
		// Timeout of 4k+3 comparisons
		for (int k = 0; k < 2; k++) begin
			w = 21'h0;
			w[`FB_FS_EN] = 1'b1;
			w[`FB_FS_CTRL] = k[0];
			w[`FB_TMO_EN] = 1'b1;
			w[`FB_TMO_MSB:`FB_TMO_LSB] = k[3:0];
			put(`TGT_FUNC, w);
			check(fsoe, 1'b0);
			put(`TGT_MAIN, 21'h10_0000);
			check(qd, k[0]);
			check(hg, 1'b1);
			repeat (4 * k + 2) comp(0);
			check(fsa, 1'b1);
			comp(0);
			check(fsa, 1'b0);
		end
		// Fast settle without timeout stays until the host clears go
		w = 21'h0;
		w[`FB_FS_EN] = 1'b1;
		put(`TGT_FUNC, w);
		put(`TGT_MAIN, 21'h10_0000);
		repeat (4) comp(0);
		check(fsa && hg && !qd, 1'b1);
		put(`TGT_MAIN, 21'h0);
		check(fsa | hg, 1'b0);
		w = 21'h0;
		w[`FB_PWRDN] = 1'b1;
		w[`FB_PWRDN_MODE] = 1'b1;
		put(`TGT_FUNC, w);
		check(pd, 1'b0);
		comp(0);
		check(pd, 1'b1);
		put(`TGT_FUNC, 21'h0);
		check(pd, 1'b0);
		w[`FB_PWRDN_MODE] = 1'b0;
		put(`TGT_FUNC, w);
		check(pd && flt && c_rst, 1'b1);
		w[`FB_PD_POL] = 1'b1;
		put(`TGT_FUNC, w);
		check(pol, 1'b1);
		put(`TGT_FUNC, 21'h0);
		ce = 1'b0;
		repeat (8) @(negedge clock);
		check(pd && flt && c_rst, 1'b1);
		ce = 1'b1;
		repeat (8) @(negedge clock);
		check(pd, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
